// file: logic/fid_map.svh
// encodings, field positions and reset values of the instruction datapath
`ifndef FID_MAP_SVH
`define FID_MAP_SVH
`define FID_OP_MOVE     3'h0
`define FID_OP_ADD      3'h1
`define FID_OP_AND      3'h2
`define FID_OP_XOR      3'h3
`define FID_OP_XEC      3'h4
`define FID_OP_NZT      3'h5
`define FID_OP_LITERAL_TRANSMIT     3'h6
`define FID_OP_JMP      3'h7
`define FID_SEL_LEFT    2'h2
`define FID_SEL_RIGHT   2'h3
`define FID_ADR_REG     2'h1
`define FID_ADR_LEFT    3'h7
`define FID_ADR_RIGHT   3'h6
`define FID_AUX_IDX     3'h0
`define FID_LEN_FULL    4'h8
`define FID_HI_LSB      8
`define FID_FETCH_RST   13'h0000
`define FID_PC_RST      13'h0001
`define FID_OVF_RST     1'b0
`define FID_BYTE_RST    8'h00
`endif

// file: logic/fid_pkg.sv
// types shared by the instruction datapath
`include "fid_map.svh"
package fid_pkg;
    typedef enum logic [2:0] {
        FID_MOVE = `FID_OP_MOVE,
        FID_ADD  = `FID_OP_ADD,
        FID_AND  = `FID_OP_AND,
        FID_XOR  = `FID_OP_XOR,
        FID_XEC  = `FID_OP_XEC,
        FID_NZT  = `FID_OP_NZT,
        FID_LITERAL_TRANSMIT = `FID_OP_LITERAL_TRANSMIT,
        FID_JMP  = `FID_OP_JMP
    } fid_op_e;
    typedef struct packed {
        fid_op_e    op;
        logic [1:0] s1;
        logic [2:0] s2;
        logic [2:0] len;
        logic [1:0] d1;
        logic [2:0] d2;
    } fid_ins_s;
    typedef struct packed {
        logic left_port_group;
        logic right_port_group;
    } fid_rd_s;
    typedef struct packed {
        logic [7:0] data;
        logic       oe;
        logic       left_port_group;
        logic       right_port_group;
        logic       select_command_line;
        logic       write_cmd;
    } fid_bus_s;
endpackage : fid_pkg

// file: logic/fid_datapath.sv
// instruction decoder and rotate/mask/alu/shift/merge datapath
// What this block does
// - 16-bit word, opcode in top three bits
// - eight classes: alu, move, transmit, jumps, execute
// - source digit picks source, second gives bank lsb or names register
// - source digit 2 left group, 3 right
// - length field gives contiguous operand bit count
// - destination digit 0/1 picks working register, except 1 with second digit 6/7 (address)
// - second source digit rotates a bank field right-justified
// - mask keeps length bits from the right
// - combine with same low bits of aux
// - bank destination shifts result left, merges
// - merge replaces only the shifted length bits
// - one length governs whole instruction cycle
// - rotate to merge done in one cycle
// - opcode 1 is add
// - destinations: register, group data, group address
// - transmit literal; move register as address
// - jump always; nonzero test branches else sequential
// - execute redirects one fetch, counter untouched
// - execute target is high counter bits with source plus literal as low byte
// - add overflow kept in one-bit register
// - address on bus raises select command line
`timescale 1ns/100ps
`default_nettype none
`include "fid_map.svh"
module fid_datapath (
    input  wire logic              clk_sys,
    input  wire logic              arst_n,
    input  wire fid_pkg::fid_ins_s instr_word,
    input  wire logic [7:0]        port_vector_bus_in,
    output logic [12:0]            fetch_address_reg,
    output var fid_pkg::fid_rd_s   rd_req,
    output var fid_pkg::fid_bus_s  bus_drive,
    output logic                   add_overflow_flag
);
    import fid_pkg::*;

    logic [12:0] fetch_q, fetch_d, pc_q, pc_d;
    logic        ovf_q, ovf_d;
    logic [7:0]  reg_q [8];
    logic [7:0]  reg_d [8];
    fid_bus_s    bus_q, bus_d;

    fid_ins_s    ins;
    logic        src_bank, alu_op, literal_transmit, ctl_read;
    logic [7:0]  src_raw, rot, mask, opnd, aux, res, lit;
    logic [7:0]  res_sh, mask_sh, merged, val, xec_lo;
    logic [15:0] rot16, sh16, msk16;
    logic [3:0]  len_eff;
    logic [2:0]  rot_amt, tgt2;
    logic [1:0]  tgt1;
    logic [8:0]  sum9, mask9;
    logic        carry;

    assign ins = instr_word;
    assign lit = {ins.len, ins.d1, ins.d2};
    // one length value feeds select, alu and merge alike
    assign len_eff = (ins.len == 3'h0) ? `FID_LEN_FULL
                                       : {1'b0, ins.len};
    assign alu_op = (ins.op == FID_MOVE) || (ins.op == FID_ADD)
                 || (ins.op == FID_AND) || (ins.op == FID_XOR);
    assign literal_transmit = (ins.op == FID_LITERAL_TRANSMIT);
    assign ctl_read = (ins.op == FID_XEC) || (ins.op == FID_NZT);
    assign src_bank = ins.s1[1];

    // input-phase group enables are combinational from the word
    always_comb begin
        rd_req.left_port_group  = (alu_op || ctl_read)
                               && (ins.s1 == `FID_SEL_LEFT);
        rd_req.right_port_group = (alu_op || ctl_read)
                               && (ins.s1 == `FID_SEL_RIGHT);
    end

    // registers are named by the second digit and never rotated
    assign src_raw = src_bank ? port_vector_bus_in : reg_q[ins.s2];
    assign rot_amt = src_bank ? ins.s2 : 3'h0;
    assign rot16   = {src_raw, src_raw} >> rot_amt;
    assign rot     = rot16[7:0];
    assign mask9   = (9'h001 << len_eff) - 9'h001;
    assign mask    = mask9[7:0];
    assign opnd    = rot & mask;
    assign aux     = reg_q[`FID_AUX_IDX] & mask;
    assign sum9    = {1'b0, opnd} + {1'b0, aux};
    assign carry   = sum9[len_eff];

    always_comb begin
        case (ins.op)
            FID_ADD: res = sum9[7:0] & mask;
            FID_AND: res = opnd & aux;
            FID_XOR: res = opnd ^ aux;
            default: res = opnd;
        endcase
    end

    // shift and merge into the source byte as read this cycle (not latched)
    assign sh16    = {8'h00, res} << ins.d2;
    assign msk16   = {8'h00, mask} << ins.d2;
    assign res_sh  = sh16[7:0];
    assign mask_sh = msk16[7:0];
    assign merged  = (src_raw & ~mask_sh)
                   | (res_sh & mask_sh);
    assign xec_lo  = src_raw + lit;

    // transmit names its target in the source digits
    assign tgt1 = literal_transmit ? ins.s1 : ins.d1;
    assign tgt2 = literal_transmit ? ins.s2 : ins.d2;
    assign val  = literal_transmit ? lit
                : (tgt1[1] ? merged : res);

    always_comb begin
        fetch_d = pc_q;
        pc_d    = pc_q + 13'h0001;
        ovf_d   = ovf_q;
        reg_d   = reg_q;
        bus_d   = '0;
        case (ins.op)
            FID_JMP: begin
                fetch_d = ins[12:0];
                pc_d    = ins[12:0] + 13'h0001;
            end
            FID_NZT: begin
                if (src_raw != 8'h00) begin
                    fetch_d = {pc_q[12:`FID_HI_LSB], lit};
                    pc_d    = {pc_q[12:`FID_HI_LSB], lit} + 13'h0001;
                end
            end
            FID_XEC: begin
                // counter stays put so sequencing resumes after target
                fetch_d = {pc_q[12:`FID_HI_LSB], xec_lo};
                pc_d    = pc_q;
            end
            default: begin
                if (ins.op == FID_ADD) begin
                    ovf_d = carry;
                end
                if (tgt1[1]) begin
                    bus_d.data             = val;
                    bus_d.oe               = 1'b1;
                    bus_d.write_cmd        = 1'b1;
                    bus_d.left_port_group  = (tgt1 == `FID_SEL_LEFT);
                    bus_d.right_port_group = (tgt1 == `FID_SEL_RIGHT);
                end else if ((tgt1 == `FID_ADR_REG)
                          && ((tgt2 == `FID_ADR_LEFT)
                           || (tgt2 == `FID_ADR_RIGHT))) begin
                    bus_d.data                = val;
                    bus_d.oe                  = 1'b1;
                    bus_d.write_cmd           = 1'b1;
                    bus_d.select_command_line = 1'b1;
                    bus_d.left_port_group  = (tgt2 == `FID_ADR_LEFT);
                    bus_d.right_port_group = (tgt2 == `FID_ADR_RIGHT);
                end else begin
                    reg_d[tgt2] = val;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            fetch_q <= `FID_FETCH_RST;
            pc_q    <= `FID_PC_RST;
            ovf_q   <= `FID_OVF_RST;
            bus_q   <= '0;
            for (int i = 0; i < 8; i++) begin
                reg_q[i] <= `FID_BYTE_RST;
            end
        end else begin
            fetch_q <= fetch_d;
            pc_q    <= pc_d;
            ovf_q   <= ovf_d;
            bus_q   <= bus_d;
            reg_q   <= reg_d;
        end
    end

    assign fetch_address_reg = fetch_q;
    assign bus_drive         = bus_q;
    assign add_overflow_flag = ovf_q;

    // checks
    logic is_addr, is_bank, is_reg;
    assign is_addr = (ins.op != FID_JMP) && (ins.op != FID_NZT)
                  && (ins.op != FID_XEC) && !tgt1[1]
                  && (tgt1 == `FID_ADR_REG)
                  && ((tgt2 == `FID_ADR_LEFT) || (tgt2 == `FID_ADR_RIGHT));
    assign is_bank = alu_op && ins.d1[1];
    assign is_reg  = alu_op && !ins.d1[1] && !is_addr;

    sequence s_xec;
        ins.op == FID_XEC;
    endsequence
    sequence s_plain;
        alu_op || literal_transmit;
    endsequence

    jmp_load_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ins.op == FID_JMP |=> fetch_q == $past(ins[12:0]))
        else $error("jump did not load fetch address");
    nzt_zero_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (ins.op == FID_NZT && src_raw == 8'h00)
        |=> fetch_q == $past(pc_q) && pc_q == $past(pc_q) + 13'h0001)
        else $error("branch taken on zero operand");
    xec_hold_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        s_xec |=> pc_q == $past(pc_q)
              && fetch_q[12:8] == $past(pc_q[12:8]))
        else $error("execute altered program counter");
    xec_resume_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        s_xec ##1 s_plain |=> fetch_q == $past(pc_q, 2))
        else $error("sequencing did not resume after execute");
    addr_sc_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        is_addr |=> bus_q.select_command_line && bus_q.oe
                 && bus_q.data == $past(val))
        else $error("address drive lacks select command");
    merge_keep_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        is_bank |=> !bus_q.select_command_line
                 && (bus_q.data & ~$past(mask_sh))
                    == ($past(src_raw) & ~$past(mask_sh)))
        else $error("merge disturbed bits outside field");
    reg_write_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        is_reg |=> reg_q[$past(ins.d2)] == ($past(res) & $past(mask))
                && !bus_q.oe)
        else $error("register destination not written");
    add_ovf_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        ins.op == FID_ADD |=> add_overflow_flag == $past(carry))
        else $error("overflow not captured on add");
    src_bank_a: assert property (@(posedge clk_sys) disable iff (!arst_n)
        (alu_op && ins.s1 == `FID_SEL_LEFT)
        |-> rd_req.left_port_group && !rd_req.right_port_group)
        else $error("left group not selected for source");

    // control classes and sequential flow
    sequence s_ctl;
        (ins.op == FID_JMP) || (ins.op == FID_NZT) || (ins.op == FID_XEC);
    endsequence
    sequence s_nzt_take;
        ins.op == FID_NZT && src_raw != 8'h00;
    endsequence
    sequence s_add;
        ins.op == FID_ADD;
    endsequence

    rd_right_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (alu_op && ins.s1 == `FID_SEL_RIGHT)
        |-> rd_req.right_port_group && !rd_req.left_port_group)
        else $error("right group not selected for source");
    rd_reg_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (alu_op && !ins.s1[1])
        |-> !rd_req.left_port_group && !rd_req.right_port_group)
        else $error("group read raised for register source");
    literal_transmit_lit_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (literal_transmit && ins.s1[1])
        |=> bus_q.oe && bus_q.data == $past(lit)
            && !bus_q.select_command_line)
        else $error("literal not driven to group");
    ovf_hold_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        (ins.op != FID_ADD)
        |=> add_overflow_flag == $past(add_overflow_flag))
        else $error("overflow changed without add");
    seq_next_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        s_plain |=> fetch_q == $past(pc_q)
                && pc_q == $past(pc_q) + 13'h0001)
        else $error("sequential fetch broken");
    nzt_take_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        s_nzt_take |=> fetch_q[7:0] == $past(lit)
                   && fetch_q[12:8] == $past(pc_q[12:8]))
        else $error("branch not taken on nonzero operand");
    jmp_pc_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        ins.op == FID_JMP |=> pc_q == $past(ins[12:0]) + 13'h0001)
        else $error("jump did not move program counter");
    xec_low_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        s_xec |=> fetch_q[7:0] == $past(src_raw) + $past(lit))
        else $error("execute target low byte wrong");
    ctl_quiet_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        s_ctl |=> !bus_q.oe)
        else $error("control instruction drove the bus");
    ctl_regs_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        s_ctl |=> reg_q[0] == $past(reg_q[0])
              && reg_q[1] == $past(reg_q[1]))
        else $error("control instruction wrote a register");
    drive_cmd_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        bus_q.oe |-> bus_q.write_cmd
                 && (bus_q.left_port_group != bus_q.right_port_group))
        else $error("bus drive without single group");
    merge_field_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        is_bank |=> ((bus_q.data >> $past(ins.d2)) & $past(mask))
                 == ($past(res) & (8'hff >> $past(ins.d2))))
        else $error("shifted field not merged");
    add_cut_a: assert property (
        @(posedge clk_sys) disable iff (!arst_n)
        s_add |-> (res & ~mask) == 8'h00)
        else $error("add result wider than length");
endmodule : fid_datapath
`default_nettype wire

// file: test/fid_port_model.sv
// port group model answering reads of the instruction datapath
`timescale 1ns/100ps
`default_nettype none
module fid_port_model (
    input  wire logic             clk_sys,
    input  wire fid_pkg::fid_rd_s rd_req,
    input  wire logic [7:0]       left_val,
    input  wire logic [7:0]       right_val,
    output logic [7:0]            port_vector_bus_in
);
    import fid_pkg::*;
    logic [7:0] last_q;
    // idle bus shows the inverse of its last value, so stale data never hits
    always_comb begin
        if (rd_req.left_port_group) begin
            port_vector_bus_in = left_val;
        end else if (rd_req.right_port_group) begin
            port_vector_bus_in = right_val;
        end else begin
            port_vector_bus_in = ~last_q;
        end
    end
    always_ff @(posedge clk_sys) begin
        last_q <= port_vector_bus_in;
    end
endmodule : fid_port_model
`default_nettype wire

// file: test/tb.sv
// self-checking bench for the instruction datapath
`timescale 1ns/100ps
`default_nettype none
module tb;
    import fid_pkg::*;
    logic        clk_sys     = 1'b0;
    logic        arst_n      = 1'b0;
    fid_ins_s    instr_word  = '0;
    logic [7:0]  pvb_in;
    logic [12:0] fetch;
    fid_rd_s     rd;
    fid_bus_s    bd;
    logic        ovf;
    int          bad_count   = 0;
    int          checks_done = 0;
    logic [2:0]  ops  [4] = '{3'h2, 3'h3, 3'h1, 3'h1};
    logic [2:0]  lens [4] = '{3'h4, 3'h0, 3'h4, 3'h0};
    logic [7:0]  exps [4] = '{8'h5c & 8'h96 & 8'h0f, 8'h5c ^ 8'h96,
                              (8'h0c + 8'h06) & 8'h0f, 8'h5c + 8'h96};
    logic [7:0]  e;
    always #5 clk_sys = ~clk_sys;
    fid_datapath DUT (.clk_sys(clk_sys), .arst_n(arst_n),
        .instr_word(instr_word), .port_vector_bus_in(pvb_in),
        .fetch_address_reg(fetch), .rd_req(rd), .bus_drive(bd),
        .add_overflow_flag(ovf));
    fid_port_model PM (.clk_sys(clk_sys), .rd_req(rd), .left_val(8'hb4),
        .right_val(8'h3c), .port_vector_bus_in(pvb_in));
    task automatic chk(input string n, input logic [12:0] x,
                       input logic [12:0] g);
        checks_done++;
        if (g !== x) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, x, g);
        end
    endtask : chk
    // word is applied just after an edge and executed by the next one
    task automatic run(input logic [2:0] op, input logic [12:0] r);
        instr_word = {op, r};
        @(posedge clk_sys);
        #1;
    endtask : run
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : final_report
    initial begin
        #2000;
        bad_count++;
        final_report();
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        chk("fetch_rst", 13'h0000, fetch);
        chk("ovf_rst", 13'h0000, {12'h0, ovf});
        chk("bus_rst", 13'h0000, bd);
        #1 arst_n = 1'b1;
        $display("test reset done");
        run(3'h6, {2'h0, 3'h0, 8'h96});
        chk("seq_fetch", 13'h0001, fetch);
        run(3'h6, {2'h0, 3'h3, 8'h5c});
        run(3'h6, {2'h1, 3'h7, 8'h05});
        chk("literal_transmit_left_adr", {8'h05, 5'b11011}, bd);
        run(3'h0, {2'h0, 3'h3, 3'h0, 2'h1, 3'h6});
        chk("move_right_adr", {8'h5c, 5'b10111}, bd);
        $display("test select done");
        // add field at bit 5, three wide, to aux, merged one bit up
        e = (8'hb4 & 8'hf1) | ((((8'hb4 >> 5) + 8'h06) & 8'h07) << 1);
        instr_word = {3'h1, 2'h2, 3'h5, 3'h3, 2'h3, 3'h1};
        #1 chk("rd_left", 13'h0002, {11'h0, rd});
        @(posedge clk_sys);
        #1 chk("add_merge", {e, 5'b10101}, bd);
        chk("add_ovf", 13'h0001, {12'h0, ovf});
        instr_word = {3'h0, 2'h3, 3'h4, 3'h0, 2'h2, 3'h0};
        #1 chk("rd_right", 13'h0001, {11'h0, rd});
        @(posedge clk_sys);
        #1 chk("rot_full", {8'hc3, 5'b11001}, bd);
        $display("test merge done");
        for (int i = 0; i < 4; i++) begin
            run(ops[i], {2'h0, 3'h3, lens[i], 2'h0, 3'h1});
            run(3'h0, {2'h0, 3'h1, 3'h0, 2'h1, 3'h6});
            chk("alu_reg", {exps[i], 5'b10111}, bd);
        end
        chk("ovf_clear", 13'h0000, {12'h0, ovf});
        $display("test alu done");
        run(3'h7, 13'h0123);
        chk("jmp", 13'h0123, fetch);
        run(3'h5, {2'h0, 3'h5, 8'h40});
        chk("nzt_zero", 13'h0124, fetch);
        run(3'h5, {2'h0, 3'h3, 8'h40});
        chk("nzt_taken", 13'h0140, fetch);
        run(3'h7, 13'h0200);
        run(3'h4, {2'h0, 3'h3, 8'h10});
        chk("xec_reg", 13'h026c, fetch);
        run(3'h0, 13'h0000);
        chk("xec_resume", 13'h0201, fetch);
        run(3'h0, 13'h0000);
        chk("seq_next", 13'h0202, fetch);
        run(3'h4, {2'h3, 3'h0, 8'h01});
        chk("xec_port", 13'h023d, fetch);
        $display("test context done");
        final_report();
    end
endmodule : tb
`default_nettype wire
